/* File: serial_status_pkg.sv */
package serial_status_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] ADDR_MODE    = 32'h0000_0008;
  localparam logic [ADDR_W-1:0] ADDR_TXBUF   = 32'h0000_000c;
  localparam logic [ADDR_W-1:0] ADDR_RXBUF   = 32'h0000_0010;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////
  // clear-only flags sit at status bits FLAG_LSB upward
  localparam int NUM_FLAGS = 5;
  localparam int FLAG_LSB  = 3;
  localparam int F_PARITY  = 0;
  localparam int F_FRAMING = 1;
  localparam int F_OVERRUN = 2;
  localparam int F_RXFULL  = 3;
  localparam int F_TXEMPTY = 4;
  localparam int BIT_TXMP  = 0;
  localparam int BIT_MODE  = 0;

  localparam logic [NUM_FLAGS-1:0] FLAGS_RST = 5'h10;
  localparam logic TXDONE_RST  = 1'h1;
  localparam logic RXMP_RST    = 1'h0;
  localparam logic TXMP_RST    = 1'h0;
  localparam logic MODE_RST    = 1'h0;
  localparam logic [BYTE_W-1:0] BUF_RST  = 8'h00;

  ////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       txReqEnable;
    logic       rxIrqEnable;
    logic       txEnable;
    logic       rxEnable;
    logic       mpFilterEnable;
    logic [2:0] spare;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = 8'h00;

  typedef struct packed {
    logic              done;
    logic              stopBit;
    logic              parityBad;
    logic              mpBit;
    logic [BYTE_W-1:0] data;
  } rx_event_s;

endpackage

/* File: serial_status_flag_logic.sv */
// Contract
// RL1: tx empty resets 1; sets while tx disabled or buffer moves to shifter.
// RL2: tx empty clears on 0 write after reading 1, or controller buffer write.
// RL3: rx full resets 0; sets when error-free byte lands in rx buffer.
// RL4: rx full clears on 0 write after reading 1, or controller buffer read.
// RL5: disabling reception leaves rx full unchanged.
// RL6: overrun resets 0; sets when a frame completes while rx full is 1.
// RL7: overrun clears only on 0 write after reading it as 1.
// RL8: framing error resets 0; sets when sampled stop bit is 0.
// RL9: with two stop bits only the first one is checked.
// RL10: framing error clears only on 0 write after reading it as 1.
// RL11: parity error resets 0; sets on parity mismatch in received frame.
// RL12: parity error clears only on 0 write after reading it as 1.
// RL13: tx complete resets 1; sets if tx disabled or empty at last bit.
// RL14: tx complete clears together with tx empty.
// RL15: received multiprocessor bit resets 0, captured from each frame.
// RL16: received multiprocessor bit holds while reception is disabled.
// RL17: transmit multiprocessor bit resets 0, software writable, sent per frame.
// RL18: software only clears the five flags; hardware alone sets them.
// RL19: this layout applies only while smartcard select is 0.
// RL20: rx irq enable gates both rx data and rx error requests.
// RL21: filter skips frames with mp bit 0; mp bit 1 clears filter.
// RL22: writing 1, or 0 without prior read of 1, leaves flag unchanged.
// RL23: set beats clear in the same cycle.
module serial_status_flag_logic
  import serial_status_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire rx_event_s         rxEvent,
  input  wire logic              txShiftLoad,
  input  wire logic              txLastBit,
  input  wire logic              xferTxWrite,
  input  wire logic [BYTE_W-1:0] xferTxData,
  input  wire logic              xferRxRead,
  output ctrl_s                  control,
  output logic                   smartcardSelect,
  output logic [BYTE_W-1:0]      txBufData,
  output logic                   txMpBit,
  output logic [BYTE_W-1:0]      rxBufData,
  output logic                   txDataRequest,
  output logic                   rxDataRequest,
  output logic                   rxErrorRequest
);

  ////////////////////////////////////////////////////////////////
  logic                 awHeld;
  logic                 wHeld;
  logic [ADDR_W-1:0]    awAddr;
  logic [DATA_W-1:0]    wData;
  logic [3:0]           wStrb;
  logic                 awTake;
  logic                 wTake;
  logic                 wrFire;
  logic                 arTake;
  logic                 wrMapped;
  logic                 rdMapped;
  logic                 wrStatus;
  logic                 wrControl;
  logic                 wrMode;
  logic                 wrTxBuf;
  logic                 rdStatus;
  logic [DATA_W-1:0]    next_rdata;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] armed;
  logic [NUM_FLAGS-1:0] setVec;
  logic [NUM_FLAGS-1:0] hwClr;
  logic [NUM_FLAGS-1:0] swClr;
  logic [NUM_FLAGS-1:0] clrVec;
  logic                 txComplete;
  logic                 rxMpBit;
  logic [BYTE_W-1:0]    statusByte;
  logic                 rxFrame;
  logic                 rxSkip;
  logic                 rxAccept;
  logic                 rxGood;
  logic                 overrun;
  logic                 frameErr;
  logic                 parErr;
  logic                 mpHit;
  logic                 txDoneSet;

  ////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign s_axi_awready = ce && !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = ce && !wHeld && !s_axi_bvalid;
  assign awTake        = s_axi_awvalid && s_axi_awready;
  assign wTake         = s_axi_wvalid && s_axi_wready;
  assign wrFire        = ce && awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (ce) begin
      if (awTake) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
    end else if (ce) begin
      if (wTake) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  assign wrMapped  = (awAddr == ADDR_STATUS) || (awAddr == ADDR_CONTROL) ||
                     (awAddr == ADDR_MODE) || (awAddr == ADDR_TXBUF);
  // registers are one byte wide, so only lane 0 matters
  assign wrStatus  = wrFire && wStrb[0] && (awAddr == ADDR_STATUS);
  assign wrControl = wrFire && wStrb[0] && (awAddr == ADDR_CONTROL);
  assign wrMode    = wrFire && wStrb[0] && (awAddr == ADDR_MODE);
  assign wrTxBuf   = wrFire && wStrb[0] && (awAddr == ADDR_TXBUF);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // read channel
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign arTake        = s_axi_arvalid && s_axi_arready;
  assign rdStatus      = arTake && (s_axi_araddr == ADDR_STATUS);
  assign statusByte    = {flags, txComplete, rxMpBit, txMpBit};

  always_comb begin
    next_rdata = '0;
    rdMapped   = 1'b1;
    case (s_axi_araddr)
      ADDR_STATUS:  next_rdata[BYTE_W-1:0] = statusByte;
      ADDR_CONTROL: next_rdata[BYTE_W-1:0] = control;
      ADDR_MODE:    next_rdata[BIT_MODE]   = smartcardSelect;
      ADDR_TXBUF:   next_rdata[BYTE_W-1:0] = txBufData;
      ADDR_RXBUF:   next_rdata[BYTE_W-1:0] = rxBufData;
      default:      rdMapped               = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // read-then-write-zero arming; drops if the flag falls meanwhile
  always_ff @(posedge clk) begin
    if (!nrst) begin
      armed <= '0;
    end else if (ce) begin
      if (rdStatus) begin
        armed <= flags;
      end else if (wrStatus) begin
        armed <= '0;
      end else begin
        armed <= armed & flags;
      end
    end
  end

  // RL22 armed zero write
  assign swClr = {NUM_FLAGS{wrStatus}} & armed &
                 ~wData[FLAG_LSB +: NUM_FLAGS];

  ////////////////////////////////////////////////////////////////
  // receive events
  assign rxFrame  = rxEvent.done && control.rxEnable;
  // RL21 filter skip
  assign rxSkip   = rxFrame && control.mpFilterEnable && !rxEvent.mpBit;
  assign mpHit    = rxFrame && control.mpFilterEnable && rxEvent.mpBit;
  assign rxAccept = rxFrame && !rxSkip;
  // RL6 overrun detect
  assign overrun  = rxAccept && flags[F_RXFULL];
  // RL8 stop bit low
  // RL9 first stop only
  // RL19 normal mode only
  assign frameErr = rxAccept && !rxEvent.stopBit && !smartcardSelect;
  // RL11 parity mismatch
  assign parErr   = rxAccept && rxEvent.parityBad;
  // RL3 clean reception
  assign rxGood   = rxAccept && !flags[F_RXFULL] && rxEvent.stopBit &&
                    !rxEvent.parityBad;

  // RL18 hardware-only set
  // RL1 empty set terms
  assign setVec[F_TXEMPTY] = !control.txEnable || txShiftLoad;
  assign setVec[F_RXFULL]  = rxGood;
  assign setVec[F_OVERRUN] = overrun;
  assign setVec[F_FRAMING] = frameErr;
  assign setVec[F_PARITY]  = parErr;

  // RL2 controller load
  // RL4 controller read
  assign hwClr[F_TXEMPTY] = xferTxWrite;
  assign hwClr[F_RXFULL]  = xferRxRead;
  // RL7 RL10 RL12 software only
  assign hwClr[F_OVERRUN] = 1'b0;
  assign hwClr[F_FRAMING] = 1'b0;
  assign hwClr[F_PARITY]  = 1'b0;
  assign clrVec        = swClr | hwClr;

  // RL23 set beats clear
  // RL5 no term on rx disable
  for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
    always_ff @(posedge clk) begin
      if (!nrst) begin
        flags[i] <= FLAGS_RST[i];
      end else if (ce) begin
        flags[i] <= setVec[i] | (flags[i] & ~clrVec[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // RL13 complete set terms
  assign txDoneSet = !control.txEnable || (txLastBit && flags[F_TXEMPTY]);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      txComplete <= TXDONE_RST;
    end else if (ce) begin
      // RL14 clears with empty
      txComplete <= txDoneSet | (txComplete & ~clrVec[F_TXEMPTY]);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxMpBit <= RXMP_RST;
    end else if (ce) begin
      // RL15 capture per frame
      // RL16 only while enabled
      if (rxFrame) begin
        rxMpBit <= rxEvent.mpBit;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      txMpBit <= TXMP_RST;
    end else if (ce) begin
      // RL17 software bit
      if (wrStatus) begin
        txMpBit <= wData[BIT_TXMP];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // buffers; a full rx buffer is never overwritten by an overrun frame
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxBufData <= BUF_RST;
    end else if (ce) begin
      if (rxGood) begin
        rxBufData <= rxEvent.data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      txBufData <= BUF_RST;
    end else if (ce) begin
      if (xferTxWrite) begin
        txBufData <= xferTxData;
      end else if (wrTxBuf) begin
        txBufData <= wData[BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      control <= CTRL_RST;
    end else if (ce) begin
      if (wrControl) begin
        control       <= ctrl_s'(wData[BYTE_W-1:0]);
        control.spare <= '0;
      end
      // RL21 filter self-clears
      if (mpHit) begin
        control.mpFilterEnable <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      smartcardSelect <= MODE_RST;
    end else if (ce) begin
      if (wrMode) begin
        smartcardSelect <= wData[BIT_MODE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  assign txDataRequest  = control.txReqEnable && flags[F_TXEMPTY];
  // RL20 rx irq enable gates both
  assign rxDataRequest  = control.rxIrqEnable && flags[F_RXFULL];
  assign rxErrorRequest = control.rxIrqEnable &&
                          (flags[F_OVERRUN] || flags[F_FRAMING] || flags[F_PARITY]);

  ////////////////////////////////////////////////////////////////
  // RL1 empty while disabled
  chk_txempty_set: assert property ( // RL1
    @(posedge clk) disable iff (!nrst)
    ce && !control.txEnable |=> flags[F_TXEMPTY] && txComplete)
    else $error("tx empty not set while tx disabled");

  // RL2 controller clears empty
  chk_txempty_clear: assert property ( // RL2
    @(posedge clk) disable iff (!nrst)
    ce && xferTxWrite && control.txEnable && !txShiftLoad
    |=> !flags[F_TXEMPTY])
    else $error("tx empty not cleared by controller write");

  // RL3 clean frame fills buffer
  chk_rxfull_set: assert property ( // RL3
    @(posedge clk) disable iff (!nrst)
    ce && rxGood |=> flags[F_RXFULL] && rxBufData == $past(rxEvent.data))
    else $error("rx full or buffer not loaded");

  // RL4 controller read clears full
  chk_rxfull_clear: assert property ( // RL4
    @(posedge clk) disable iff (!nrst)
    ce && xferRxRead && !rxGood |=> !flags[F_RXFULL])
    else $error("rx full not cleared by controller read");

  // RL5 rx disable keeps full
  chk_rxfull_hold: assert property ( // RL5
    @(posedge clk) disable iff (!nrst)
    ce && !control.rxEnable && !xferRxRead && !swClr[F_RXFULL]
    |=> $stable(flags[F_RXFULL]))
    else $error("rx full changed while rx disabled");

  // RL6 overrun on full buffer
  chk_overrun_set: assert property ( // RL6
    @(posedge clk) disable iff (!nrst)
    ce && rxAccept && flags[F_RXFULL]
    |=> flags[F_OVERRUN] && $stable(rxBufData))
    else $error("overrun missed or buffer overwritten");

  // RL7 RL10 RL12 software only clear
  chk_error_clear: assert property ( // RL7
    @(posedge clk) disable iff (!nrst)
    $fell(flags[F_OVERRUN]) || $fell(flags[F_FRAMING]) || $fell(flags[F_PARITY])
    |-> $past(wrStatus && armed != '0))
    else $error("error flag cleared without armed write");

  // RL8 RL9 first stop bit low
  chk_framing_set: assert property ( // RL8
    @(posedge clk) disable iff (!nrst)
    ce && rxAccept && !rxEvent.stopBit && !smartcardSelect
    |=> flags[F_FRAMING])
    else $error("framing error not flagged");

  // RL11 parity mismatch flagged
  chk_parity_set: assert property ( // RL11
    @(posedge clk) disable iff (!nrst)
    ce && rxAccept && rxEvent.parityBad |=> flags[F_PARITY])
    else $error("parity error not flagged");

  // RL13 last bit with empty
  chk_txdone_set: assert property ( // RL13
    @(posedge clk) disable iff (!nrst)
    ce && txLastBit && flags[F_TXEMPTY] |=> txComplete)
    else $error("tx complete not set at last bit");

  // RL14 complete follows empty clear
  chk_txdone_clear: assert property ( // RL14
    @(posedge clk) disable iff (!nrst)
    ce && clrVec[F_TXEMPTY] && !txDoneSet |=> !txComplete)
    else $error("tx complete not cleared with tx empty");

  // RL16 mp bit holds when off
  chk_rxmp_hold: assert property ( // RL16
    @(posedge clk) disable iff (!nrst)
    ce && !control.rxEnable |=> $stable(rxMpBit))
    else $error("rx mp bit changed while rx disabled");

  // RL18 no software set
  chk_no_swset: assert property ( // RL18
    @(posedge clk) disable iff (!nrst)
    $rose(flags[F_PARITY]) |-> $past(setVec[F_PARITY]))
    else $error("parity flag rose without hardware cause");

  // RL21 skipped frame ignored
  chk_filter_skip: assert property ( // RL21
    @(posedge clk) disable iff (!nrst)
    ce && rxSkip && !flags[F_RXFULL]
    |=> !flags[F_RXFULL] && (control.mpFilterEnable || $past(wrControl)))
    else $error("filtered frame was accepted");

  // RL22 write one keeps flag
  chk_write_one: assert property ( // RL22
    @(posedge clk) disable iff (!nrst)
    ce && wrStatus && flags[F_OVERRUN] && wData[FLAG_LSB + F_OVERRUN]
    |=> flags[F_OVERRUN])
    else $error("writing one cleared a flag");

  // RL23 set wins
  chk_set_wins: assert property ( // RL23
    @(posedge clk) disable iff (!nrst)
    ce && setVec[F_RXFULL] && clrVec[F_RXFULL] |=> flags[F_RXFULL])
    else $error("simultaneous clear beat the set");

endmodule

/* File: serial_line_model.sv */
timeunit 1ns;
timeprecision 1ps;
// far-side transceiver: delivers frames and walks the tx shifter, after lag cycles
module serial_line_model
  import serial_status_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       frameReq,
  input  wire rx_event_s  frameCfg,
  input  wire logic       txReq,
  input  wire logic [3:0] lag,
  output rx_event_s       rxEvent,
  output logic            txShiftLoad,
  output logic            txLastBit,
  output logic            busy
);
  logic [4:0] cnt;
  logic       isTx;
  rx_event_s  held;
  logic       noise;
  logic       done;

  assign busy = (cnt != 5'h00);
  assign done = busy && !isTx && (cnt == 5'h01);
  // shifter load, then eight bit times later the last bit of a one-byte char
  assign txShiftLoad = busy && isTx && (cnt == 5'h09);
  assign txLastBit   = busy && isTx && (cnt == 5'h01);
  // first stop bit sample only
  // fields toggle between frames so stale values are never mistaken for data
  assign rxEvent = done ? {1'b1, held.stopBit, held.parityBad, held.mpBit, held.data}
                        : {1'b0, noise, ~noise, noise, {4{noise, ~noise}}};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt   <= 5'h00;
      isTx  <= 1'b0;
      held  <= '0;
      noise <= 1'b0;
    end else begin
      noise <= ~noise;
      if (frameReq || txReq) begin
        cnt  <= {1'b0, lag} + (txReq ? 5'h09 : 5'h01);
        isTx <= txReq;
        held <= frameCfg;
      end else if (busy) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule

/* File: tb_top.sv */
timeunit 1ns;
timeprecision 1ps;
module tb_top
  import serial_status_pkg::*;
;
  logic              clk, nrst, ce;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  rx_event_s         rxEvent, frameCfg;
  logic              txShiftLoad, txLastBit, xferTxWrite, xferRxRead;
  logic [BYTE_W-1:0] xferTxData, txBufData, rxBufData;
  ctrl_s             control;
  logic              smartcardSelect, txMpBit, txDataRequest, rxDataRequest, rxErrorRequest;
  logic              frameReq, txReq, busy;
  logic [3:0]        lag;
  int                failures, nChecks, cycles;

  serial_status_flag_logic u_serial_status_flag_logic (
    .clk, .nrst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rxEvent, .txShiftLoad, .txLastBit, .xferTxWrite, .xferTxData, .xferRxRead,
    .control, .smartcardSelect, .txBufData, .txMpBit, .rxBufData, .txDataRequest,
    .rxDataRequest, .rxErrorRequest);

  serial_line_model u_serial_line_model (
    .clk, .nrst, .frameReq, .frameCfg, .txReq, .lag, .rxEvent, .txShiftLoad, .txLastBit, .busy);

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                     input string what);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                           input logic [1:0] er = RESP_OKAY);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone  = 1'b0;
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d}; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && s_axi_awready === 1'b1) begin awDone = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!wDone && s_axi_wready === 1'b1) begin wDone = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er, "bresp");
  endtask

  task automatic axi_read(input logic [ADDR_W-1:0] a, input logic [7:0] ed,
                          input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h000000, ed}, "rdata");
    chk(s_axi_rresp, er, "rresp");
  endtask

  task automatic line_op(input logic tx, input logic s, input logic p, input logic m,
                         input logic [7:0] d);
    frameCfg <= {1'b0, s, p, m, d}; frameReq <= !tx; txReq <= tx;
    @(posedge clk);
    frameReq <= 1'b0; txReq <= 1'b0;
    do @(posedge clk); while (busy === 1'b1);
  endtask

  task automatic xfer(input logic tx, input logic [7:0] d);
    xferTxData <= d; xferTxWrite <= tx; xferRxRead <= !tx;
    @(posedge clk);
    xferTxWrite <= 1'b0; xferRxRead <= 1'b0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0; nrst = 1'b0; ce = 1'b1; lag = 4'h0;
    s_axi_awaddr = '0; s_axi_awvalid = 1'b0; s_axi_wdata = '0; s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = '0; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0; frameCfg = '0; frameReq = 1'b0; txReq = 1'b0;
    xferTxWrite = 1'b0; xferTxData = 8'h00; xferRxRead = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    axi_read(ADDR_STATUS, 8'h84);
    axi_read(ADDR_CONTROL, 8'h00);
    axi_read(32'h0000_0040, 8'h00, RESP_SLVERR);
    axi_write(ADDR_RXBUF, 8'h55, RESP_SLVERR);
    $display("test reset done");
    // clear attempt loses while tx disabled
    axi_write(ADDR_STATUS, 8'h00);
    axi_read(ADDR_STATUS, 8'h84);
    axi_write(ADDR_CONTROL, 8'h20);
    axi_read(ADDR_STATUS, 8'h84);
    axi_write(ADDR_STATUS, 8'h01);
    axi_read(ADDR_STATUS, 8'h01);
    chk(txMpBit, 1'b1, "tx mp bit");
    axi_write(ADDR_STATUS, 8'hfe);
    axi_read(ADDR_STATUS, 8'h00);
    $display("test tx clear done");
    line_op(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
    axi_read(ADDR_STATUS, 8'h84);
    chk(txDataRequest, 1'b0, "tx data request");
    xfer(1'b1, 8'h3c);
    axi_read(ADDR_STATUS, 8'h00);
    chk(txBufData, 8'h3c, "tx buffer");
    $display("test tx events done");
    axi_write(ADDR_CONTROL, 8'h70);
    line_op(1'b0, 1'b1, 1'b0, 1'b1, 8'ha5);
    axi_read(ADDR_STATUS, 8'h42);
    chk(rxBufData, 8'ha5, "rx buffer");
    chk(rxDataRequest, 1'b1, "rx data request");
    lag <= 4'h7;
    line_op(1'b0, 1'b1, 1'b0, 1'b0, 8'h5a);
    axi_read(ADDR_STATUS, 8'h60);
    chk(rxBufData, 8'ha5, "rx buffer kept");
    chk(rxErrorRequest, 1'b1, "rx error request");
    axi_write(ADDR_STATUS, 8'hff);
    axi_write(ADDR_STATUS, 8'h00);
    axi_read(ADDR_STATUS, 8'h60);
    axi_write(ADDR_STATUS, 8'h40);
    axi_read(ADDR_STATUS, 8'h40);
    xfer(1'b0, 8'h00);
    axi_read(ADDR_STATUS, 8'h00);
    $display("test rx overrun done");
    line_op(1'b0, 1'b0, 1'b0, 1'b0, 8'h0f);
    line_op(1'b0, 1'b1, 1'b1, 1'b0, 8'hf0);
    axi_read(ADDR_STATUS, 8'h18);
    axi_write(ADDR_STATUS, 8'h00);
    axi_read(ADDR_STATUS, 8'h00);
    $display("test rx errors done");
    lag <= 4'h0;
    line_op(1'b0, 1'b1, 1'b0, 1'b1, 8'h77);
    axi_write(ADDR_CONTROL, 8'h60);
    line_op(1'b0, 1'b1, 1'b0, 1'b0, 8'h11);
    axi_read(ADDR_STATUS, 8'h42);
    chk(rxBufData, 8'h77, "rx buffer held");
    xfer(1'b0, 8'h00);
    $display("test rx disabled done");
    // filtered frames may carry errors too: nothing may set
    axi_write(ADDR_CONTROL, 8'h78);
    line_op(1'b0, 1'b1, 1'b0, 1'b0, 8'h99);
    line_op(1'b0, 1'b0, 1'b0, 1'b0, 8'h98);
    axi_read(ADDR_STATUS, 8'h00);
    axi_read(ADDR_CONTROL, 8'h78);
    line_op(1'b0, 1'b1, 1'b0, 1'b1, 8'hc3);
    axi_read(ADDR_STATUS, 8'h42);
    axi_read(ADDR_CONTROL, 8'h70);
    chk(rxBufData, 8'hc3, "rx buffer filtered");
    axi_write(ADDR_MODE, 8'h01);
    chk(smartcardSelect, 1'b1, "smartcard select");
    axi_write(ADDR_MODE, 8'h00);
    $display("test filter done");
    final_report();
  end
endmodule
